// ===== ioas_status_unit.sv
// Alarm status, indicator and data-gating logic of the analog I/O unit
`timescale 1ns/10ps
module ioas_status_unit #(
  parameter int unsigned BLINK_CYC = ioas_pkg::BLINK_CYC,
  parameter int unsigned DATA_W = 16
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic refresh_i,
  input wire logic restart_bit_i,
  input wire logic adjust_mode_i,
  input wire logic adj_in_range_i,
  input wire logic [7:0] adj_chan_i,
  input wire logic [7:0] chan_enabled_i,
  input wire logic host_run_mode_i,
  input wire logic bus_error_i,
  input wire logic host_timeout_i,
  input wire logic host_wdt_i,
  input wire logic unit_dup_i,
  input wire logic table_mismatch_i,
  input wire logic [7:0] unit_number_i,
  input wire logic ratio_chan_used_i,
  input wire logic scaling_en_i,
  input wire logic [15:0] scale_upper_i,
  input wire logic [15:0] scale_lower_i,
  input wire logic [15:0] ratio_set_i,
  input wire logic [15:0] hold_sel_i,
  input wire logic [15:0] avg_count_i,
  input wire logic [7:0] conv_mode_i,
  input wire logic [15:0] out_set_i,
  input wire logic [15:0] live_data_i,
  output logic [15:0] status_word_o,
  output logic [15:0] conv_data_o,
  output logic [15:0] out_value_o,
  output logic [15:0] base_addr_o,
  output logic conv_run_o,
  output logic run_led_o,
  output logic unit_error_led_o,
  output logic host_error_led_o,
  output logic adjusting_led_o
);
  localparam int unsigned SYNC_W = 140;
  typedef enum logic [2:0] {ST_RESTART, ST_RUN, ST_INIT_ERR, ST_UNIT_ERR,
    ST_ADJ_HALT} ioas_state_e;
  if (DATA_W != 16) begin : g_bad_data
    $error("ioas_status_unit supports 16-bit data words only");
  end
  if (BLINK_CYC < 2 || BLINK_CYC >= (1 << ioas_pkg::CNT_W)) begin : g_bad_bl
    $error("ioas_status_unit blink count out of counter range");
  end
  logic [SYNC_W-1:0] raw_w;
  logic [SYNC_W-1:0] syn_w;
  logic refresh_s, restart_s, adj_s, in_range_s, run_mode_s;
  logic bus_err_s, timeout_s, wdt_s, dup_s, mismatch_s;
  logic ratio_used_s, scale_en_s;
  logic [7:0] adj_chan_s, chan_en_s, unit_s, mode_s;
  logic [15:0] upper_s, lower_s, ratio_s, hold_s, avg_s, out_set_s;
  // Every host-side setting crosses in through two flops
  assign raw_w = {refresh_i, restart_bit_i, adjust_mode_i, adj_in_range_i,
                  host_run_mode_i, bus_error_i, host_timeout_i, host_wdt_i,
                  unit_dup_i, table_mismatch_i, ratio_chan_used_i,
                  scaling_en_i, adj_chan_i, chan_enabled_i, unit_number_i,
                  conv_mode_i, scale_upper_i, scale_lower_i, ratio_set_i,
                  hold_sel_i, avg_count_i, out_set_i};
  ioas_sync #(.W(SYNC_W)) u_sync (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .async_i(raw_w),
    .sync_o(syn_w)
  );
  assign {refresh_s, restart_s, adj_s, in_range_s, run_mode_s, bus_err_s,
          timeout_s, wdt_s, dup_s, mismatch_s, ratio_used_s, scale_en_s,
          adj_chan_s, chan_en_s, unit_s, mode_s, upper_s, lower_s,
          ratio_s, hold_s, avg_s, out_set_s} = syn_w;
  // Edge detectors look only at synchronised levels
  logic refresh_d_q, restart_d_q, refresh_p, restart_fall;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      refresh_d_q <= 1'b0;
      restart_d_q <= 1'b0;
    end else begin
      refresh_d_q <= refresh_s;
      restart_d_q <= restart_s;
    end
  end

  assign refresh_p = refresh_s && !refresh_d_q;
  assign restart_fall = restart_d_q && !restart_s; // [RULE21]
  // Adjustment channel must be 11..14 or 21..24 and enabled
  logic chan_ok, chan_bad, range_bad;
  always_comb begin
    chan_ok = 1'b0;
    if (adj_chan_s >= 8'h11 && adj_chan_s <= 8'h14) begin
      chan_ok = chan_en_s[{1'b0, adj_chan_s[1:0] - 2'h1}];
    end else if (adj_chan_s >= 8'h21 && adj_chan_s <= 8'h24) begin
      chan_ok = chan_en_s[{1'b1, adj_chan_s[1:0] - 2'h1}];
    end
  end

  assign chan_bad = !chan_ok; // [RULE3]
  assign range_bad = !in_range_s; // [RULE2]
  // Startup sequencer with restart counter
  ioas_state_e state_q, state_d;
  logic [7:0] rst_cnt_q;
  logic [15:0] init_flags_q;
  logic [1:0] hold_mode_q;
  logic unit_bad;
  logic [15:0] flags_now;
  assign unit_bad = dup_s || mismatch_s ||
                    (unit_s > ioas_pkg::UNIT_MAX); // [RULE17] [RULE18]
  assign flags_now = ioas_pkg::init_flags(ratio_used_s, scale_en_s,
                       upper_s, lower_s, ratio_s, hold_s, avg_s, mode_s);
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESTART: begin
        if (rst_cnt_q == 8'h00) begin
          if (unit_bad) begin
            state_d = ST_UNIT_ERR;
          end else if (!adj_s && flags_now != 16'h0000) begin
            state_d = ST_INIT_ERR; // [RULE6]
          end else begin
            state_d = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if (adj_s && run_mode_s) begin
          state_d = ST_ADJ_HALT; // [RULE4]
        end
      end
      ST_INIT_ERR: state_d = ST_INIT_ERR; // [RULE7]
      ST_UNIT_ERR: state_d = ST_UNIT_ERR;
      ST_ADJ_HALT: state_d = ST_ADJ_HALT;
      default: state_d = ST_RESTART;
    endcase
    // Only a restart leaves a latched fault state
    if (restart_fall) begin
      state_d = ST_RESTART; // [RULE21] [RULE7]
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_RESTART;
    end else begin
      state_q <= state_d;
    end
  end

  // Restart time counts down from each restart entry
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_cnt_q <= 8'(ioas_pkg::RESTART_CYC);
    end else if (state_d == ST_RESTART && state_q != ST_RESTART) begin
      rst_cnt_q <= 8'(ioas_pkg::RESTART_CYC);
    end else if (state_q == ST_RESTART && rst_cnt_q != 8'h00) begin
      rst_cnt_q <= rst_cnt_q - 8'h01;
    end
  end

  // Settings are captured once, at the end of restart
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      init_flags_q <= ioas_pkg::STATUS_RESET;
      hold_mode_q <= ioas_pkg::HOLD_CLEAR;
    end else if (state_q == ST_RESTART && rst_cnt_q == 8'h00) begin
      init_flags_q <= flags_now; // [RULE7]
      hold_mode_q <= hold_s[1:0];
    end
  end

  // Status word content for the current condition
  logic [15:0] stat_d;
  always_comb begin
    stat_d = ioas_pkg::STATUS_RESET;
    case (state_q)
      ST_ADJ_HALT: stat_d = ioas_pkg::STATUS_HALT; // [RULE4]
      ST_INIT_ERR: stat_d = init_flags_q; // [RULE6]
      ST_RUN: begin
        if (adj_s) begin
          stat_d[ioas_pkg::BIT_ADJ_ON] = 1'b1; // [RULE1]
          stat_d[ioas_pkg::BIT_ADJ_CHAN] = chan_bad; // [RULE3]
          stat_d[ioas_pkg::BIT_MODE] = range_bad && !chan_bad; // [RULE2]
        end
      end
      default: stat_d = ioas_pkg::STATUS_RESET;
    endcase
  end

  // Host sees the word change only at its refresh
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_word_o <= ioas_pkg::STATUS_RESET;
    end else if (refresh_p) begin
      status_word_o <= stat_d; // [RULE22]
    end
  end

  // Value applied to outputs while conversion is cut off
  logic [15:0] held_out;
  always_comb begin
    case (hold_mode_q)
      ioas_pkg::HOLD_CLEAR: held_out = ioas_pkg::DATA_ZERO;
      ioas_pkg::HOLD_LAST: held_out = out_value_o;
      ioas_pkg::HOLD_FULL: held_out = ioas_pkg::OUT_FULL;
      default: held_out = ioas_pkg::DATA_ZERO;
    endcase
  end

  // Conversion data gating
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      conv_data_o <= ioas_pkg::DATA_ZERO;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (timeout_s) begin
            conv_data_o <= conv_data_o; // [RULE15]
          end else if (bus_err_s) begin
            conv_data_o <= ioas_pkg::DATA_ZERO; // [RULE14]
          end else if (wdt_s) begin
            conv_data_o <= conv_data_o; // [RULE16]
          end else if (adj_s && chan_bad) begin
            conv_data_o <= conv_data_o; // [RULE3]
          end else begin
            conv_data_o <= live_data_i; // [RULE2]
          end
        end
        ST_ADJ_HALT: conv_data_o <= conv_data_o; // [RULE4]
        default: conv_data_o <= ioas_pkg::DATA_ZERO; // [RULE20] [RULE6]
      endcase
    end
  end
  // Analog output value gating
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_value_o <= ioas_pkg::DATA_ZERO;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (timeout_s) begin
            out_value_o <= out_value_o; // [RULE15]
          end else if (bus_err_s || wdt_s) begin
            out_value_o <= held_out; // [RULE14] [RULE16]
          end else if (adj_s && chan_bad) begin
            out_value_o <= out_value_o; // [RULE3]
          end else begin
            out_value_o <= out_set_s;
          end
        end
        ST_ADJ_HALT: out_value_o <= out_value_o; // [RULE4]
        default: out_value_o <= ioas_pkg::DATA_ZERO; // [RULE20] [RULE17]
      endcase
    end
  end
  // Status base word follows the unit number
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      base_addr_o <= ioas_pkg::BASE_WORD;
    end else begin
      base_addr_o <= ioas_pkg::BASE_WORD +
                     16'({8'h00, unit_s} * ioas_pkg::BASE_STEP); // [RULE19]
    end
  end
  // Blink timer for the adjusting indicator
  logic [ioas_pkg::CNT_W-1:0] blink_cnt_q;
  logic blink_q;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
    end else if (blink_cnt_q == ioas_pkg::CNT_W'(BLINK_CYC - 1)) begin
      blink_cnt_q <= '0;
      blink_q <= !blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 1'b1;
    end
  end
  // Indicators; unit error covers adjustment alarms too
  logic adj_fault;
  assign adj_fault = state_q == ST_RUN && adj_s && (chan_bad || range_bad);
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_led_o <= 1'b0;
      conv_run_o <= 1'b0;
      unit_error_led_o <= 1'b0;
      host_error_led_o <= 1'b0;
      adjusting_led_o <= 1'b0;
    end else begin
      run_led_o <= state_q == ST_RUN; // [RULE6]
      conv_run_o <= state_q == ST_RUN && !adj_s; // [RULE17]
      unit_error_led_o <= state_q == ST_INIT_ERR ||
                          state_q == ST_ADJ_HALT || adj_fault; // [RULE6]
      host_error_led_o <= state_q == ST_UNIT_ERR || (state_q == ST_RUN &&
                          (bus_err_s || timeout_s || wdt_s)); // [RULE14]
      adjusting_led_o <= adj_s && blink_q &&
                         (state_q == ST_RUN || state_q == ST_ADJ_HALT);
    end
  end
  // Checks on the behaviour above
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  chk_adj_flag_set: assert property ( // [RULE1]
    state_q == ST_RUN && adj_s && refresh_p |=> status_word_o[15])
    else $error("adjust flag missing");
  chk_adj_range_bit: assert property ( // [RULE2]
    state_q == ST_RUN && adj_s && !chan_bad && range_bad && refresh_p
    |=> status_word_o[12]) else $error("adjust range bit missing");
  chk_halt_only15: assert property ( // [RULE4]
    state_q == ST_ADJ_HALT && refresh_p |=> status_word_o == 16'h8000)
    else $error("halt status not bit 15 only");
  chk_init_err_out: assert property ( // [RULE6]
    state_q == ST_INIT_ERR |=> conv_data_o == 16'h0000 &&
    unit_error_led_o && !run_led_o) else $error("init fault outputs");
  chk_flags_held: assert property ( // [RULE7]
    state_q == ST_INIT_ERR && !restart_fall |=> state_q == ST_INIT_ERR &&
    $stable(init_flags_q)) else $error("init flags dropped");
  chk_bus_zero: assert property ( // [RULE14]
    state_q == ST_RUN && bus_err_s && !timeout_s && !restart_fall
    |=> conv_data_o == 16'h0000 && host_error_led_o)
    else $error("bus error data not zero");
  chk_timeout_hold: assert property ( // [RULE15]
    state_q == ST_RUN && timeout_s && !restart_fall
    |=> $stable(conv_data_o) && $stable(out_value_o))
    else $error("timeout did not hold");
  chk_unit_err_out: assert property ( // [RULE17]
    state_q == ST_UNIT_ERR |=> host_error_led_o && !conv_run_o &&
    out_value_o == 16'h0000) else $error("unit number fault outputs");
  chk_restart_zero: assert property ( // [RULE20]
    state_q == ST_RESTART |=> conv_data_o == 16'h0000 &&
    out_value_o == 16'h0000) else $error("restart data not zero");
  chk_restart_seq: assert property ( // [RULE21]
    restart_s ##1 !restart_s |=> state_q == ST_RESTART)
    else $error("restart sequence ignored");
endmodule

// ===== ioas_common.sv
// Shared constants, setting checks and the input synchroniser
// Notes on behaviour
// (RULE1) Adjustment mode shows bit 15 set
// (RULE2) Adjust input out of range: bit 12, live data
// (RULE3) Bad adjust channel: bit 13, data unchanged
// (RULE4) Host running during adjust: only bit 15, hold
// (RULE5) Host rewrites mode byte then restarts module
// (RULE6) Bad settings: unit error lit, data zero, stopped
// (RULE7) Setting flags held until restart
// (RULE8) Ratio channel unused sets bit 08
// (RULE9) Bad scaling limits also set bit 08
// (RULE10) Ratio value not BCD 0..9999 sets bit 09
// (RULE11) Hold selection above 0002 sets bit 10
// (RULE12) Averaging count above 0006 sets bit 11
// (RULE13) Mode code not 00 or C1 sets bit 12
// (RULE14) Bus failure: host error, data zero, hold rule
// (RULE15) Host silent: inputs and outputs frozen
// (RULE16) Host watchdog: data undefined, outputs hold rule
// (RULE17) Bad unit number: host error, zero everything
// (RULE18) Module table mismatch: same as bad number
// (RULE19) Status base is 2000 plus ten times unit
// (RULE20) During restart data zero, outputs zero
// (RULE21) Restart on restart bit set then cleared
// (RULE22) Status word refreshed every host refresh
package ioas_pkg;
  // Alarm status bit positions
  localparam int unsigned BIT_RATIO = 8;
  localparam int unsigned BIT_RVAL = 9;
  localparam int unsigned BIT_HOLD = 10;
  localparam int unsigned BIT_AVG = 11;
  localparam int unsigned BIT_MODE = 12;
  localparam int unsigned BIT_ADJ_CHAN = 13;
  localparam int unsigned BIT_ADJ_ON = 15;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] STATUS_HALT = 16'h8000;
  localparam logic [15:0] DATA_ZERO = 16'h0000;
  localparam logic [15:0] OUT_FULL = 16'hFFFF;
  // Setting limits
  localparam logic [15:0] HOLD_MAX = 16'h0002;
  localparam logic [15:0] AVG_MAX = 16'h0006;
  localparam logic [7:0] MODE_DEFAULT = 8'h00;
  localparam logic [7:0] MODE_ALT = 8'hC1;
  localparam logic [7:0] UNIT_MAX = 8'h5F;
  // Output hold selections
  localparam logic [1:0] HOLD_CLEAR = 2'h0;
  localparam logic [1:0] HOLD_LAST = 2'h1;
  localparam logic [1:0] HOLD_FULL = 2'h2;
  // Status word base address
  localparam logic [15:0] BASE_WORD = 16'h07D0;
  localparam logic [15:0] BASE_STEP = 16'h000A;
  // Timing at the 10 MHz system clock
  localparam int unsigned CLK_NS = 100;
  localparam int unsigned RESTART_NS = 1000;
  localparam int unsigned RESTART_CYC = (RESTART_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned BLINK_MS = 500;
  localparam int unsigned BLINK_CYC = BLINK_MS * 1000000 / CLK_NS;
  localparam int unsigned CNT_W = 24;

  // True when every nibble is a decimal digit
  function automatic logic is_bcd(input logic [15:0] v);
    is_bcd = (v[3:0] < 4'hA) && (v[7:4] < 4'hA) &&
             (v[11:8] < 4'hA) && (v[15:12] < 4'hA);
  endfunction

  // Initial-setting fault flags, bits 08 to 12
  function automatic logic [15:0] init_flags(
    input logic ratio_used, input logic scale_en,
    input logic [15:0] upper, input logic [15:0] lower,
    input logic [15:0] ratio, input logic [15:0] hold,
    input logic [15:0] avg, input logic [7:0] mode);
    logic scale_bad;
    scale_bad = scale_en && (!is_bcd(upper) || !is_bcd(lower) ||
                ((upper == lower) && (upper != 16'h0000))); // [RULE9]
    init_flags = 16'h0000;
    init_flags[BIT_RATIO] = !ratio_used || scale_bad; // [RULE8]
    init_flags[BIT_RVAL] = !is_bcd(ratio); // [RULE10]
    init_flags[BIT_HOLD] = hold > HOLD_MAX; // [RULE11]
    init_flags[BIT_AVG] = avg > AVG_MAX; // [RULE12]
    init_flags[BIT_MODE] = (mode != MODE_DEFAULT) &&
                           (mode != MODE_ALT); // [RULE13]
  endfunction
endpackage

`timescale 1ns/10ps
// Two-flop synchroniser for a bundle of host-side levels
module ioas_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;

  if (W < 1) begin : g_bad_w
    $error("ioas_sync width must be at least one");
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

// ===== ioas_host_model.sv
// Host processor model: I/O refresh, restart bit and host fault levels
`timescale 1ns/10ps
module ioas_host_model (
  input wire logic clk_sys_i,
  input wire logic [15:0] status_word_i,
  output logic refresh_o,
  output logic restart_o,
  output logic run_mode_o,
  output logic bus_err_o,
  output logic timeout_o,
  output logic wdt_o
);
  // Host starts idle in program mode with a healthy bus
  initial begin
    refresh_o = 1'b0;
    restart_o = 1'b0;
    run_mode_o = 1'b0;
    bus_err_o = 1'b0;
    timeout_o = 1'b0;
    wdt_o = 1'b0;
  end

  // One refresh pulse, then low long enough for the word to land
  task automatic read_status(output logic [15:0] v);
    @(posedge clk_sys_i);
    refresh_o <= 1'b1;
    @(posedge clk_sys_i);
    refresh_o <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    #1;
    v = status_word_i;
  endtask

  // Restart bit set, held past the synchroniser, then cleared
  task automatic pulse_restart();
    @(posedge clk_sys_i);
    restart_o <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    restart_o <= 1'b0;
  endtask

  // Host-side fault and mode levels
  task automatic set_faults(input logic run, input logic bus,
                            input logic tmo, input logic wdt);
    @(posedge clk_sys_i);
    run_mode_o <= run;
    bus_err_o <= bus;
    timeout_o <= tmo;
    wdt_o <= wdt;
  endtask
endmodule

// ===== ioas_status_unit_tb.sv
// Self-checking bench for the alarm status and data-gating unit
`timescale 1ns/10ps
module ioas_status_unit_tb;
  typedef struct packed {
    logic used;
    logic scl;
    logic [15:0] up;
    logic [15:0] lo;
    logic [15:0] ratio;
    logic [15:0] hold;
    logic [15:0] avg;
    logic [7:0] mode;
    logic [15:0] st;
  } ioas_row_s;
  // Settings rows and the flag word each should give after restart
  ioas_row_s rows [13] = '{
    '{1'b1,1'b0,16'h0000,16'h0000,16'h0000,16'h0002,16'h0000,8'h00,16'h0000},
    '{1'b0,1'b0,16'h0000,16'h0000,16'h0000,16'h0002,16'h0000,8'h00,16'h0100},
    '{1'b1,1'b1,16'h0100,16'h0100,16'h0000,16'h0002,16'h0000,8'h00,16'h0100},
    '{1'b1,1'b1,16'h0000,16'h0000,16'h0000,16'h0002,16'h0000,8'h00,16'h0000},
    '{1'b1,1'b1,16'h00A0,16'h0010,16'h0000,16'h0002,16'h0000,8'h00,16'h0100},
    '{1'b1,1'b0,16'h0000,16'h0000,16'h9999,16'h0002,16'h0000,8'h00,16'h0000},
    '{1'b1,1'b0,16'h0000,16'h0000,16'h1A00,16'h0002,16'h0000,8'h00,16'h0200},
    '{1'b1,1'b0,16'h0000,16'h0000,16'h0000,16'h0003,16'h0000,8'h00,16'h0400},
    '{1'b1,1'b0,16'h0000,16'h0000,16'h0000,16'h0002,16'h0006,8'h00,16'h0000},
    '{1'b1,1'b0,16'h0000,16'h0000,16'h0000,16'h0002,16'h0007,8'h00,16'h0800},
    '{1'b1,1'b0,16'h0000,16'h0000,16'h0000,16'h0002,16'h0000,8'hC1,16'h0000},
    '{1'b1,1'b0,16'h0000,16'h0000,16'h0000,16'h0002,16'h0000,8'h01,16'h1000},
    '{1'b1,1'b0,16'h0000,16'h0000,16'h0000,16'h0003,16'h0007,8'h00,16'h0C00}};
  logic [7:0] achan [5] = '{8'h15, 8'h11, 8'h11, 8'h24, 8'h24};
  logic [7:0] aen [5] = '{8'hFF, 8'hFE, 8'hFF, 8'h7F, 8'hFF};
  logic arng [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  logic [15:0] ast [5] = '{16'hA000, 16'hA000, 16'h9000, 16'hA000, 16'h8000};
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic refresh_i, restart_bit_i, host_run_mode_i, bus_error_i;
  logic host_timeout_i, host_wdt_i, prev;
  logic adjust_mode_i = 1'b0, adj_in_range_i = 1'b1;
  logic unit_dup_i = 1'b0, table_mismatch_i = 1'b0;
  logic ratio_chan_used_i = 1'b1, scaling_en_i = 1'b0;
  logic [7:0] adj_chan_i = 8'h11, chan_enabled_i = 8'hFF;
  logic [7:0] unit_number_i = 8'h0C, conv_mode_i = 8'h00;
  logic [15:0] scale_upper_i = 16'h0000, scale_lower_i = 16'h0000;
  logic [15:0] ratio_set_i = 16'h0000, hold_sel_i = 16'h0002;
  logic [15:0] avg_count_i = 16'h0000, out_set_i = 16'h0555;
  logic [15:0] live_data_i = 16'h1234, st;
  logic [15:0] status_word_o, conv_data_o, out_value_o, base_addr_o;
  logic conv_run_o, run_led_o, unit_error_led_o, host_error_led_o;
  logic adjusting_led_o;
  int mismatches = 0, checks = 0, cyc = 0, i, n;

  always #50 clk_sys_i = ~clk_sys_i;

  // Short blink count keeps the indicator test brief
  ioas_status_unit #(.BLINK_CYC(4)) uut (
    .clk_sys_i, .reset_n_i, .refresh_i, .restart_bit_i, .adjust_mode_i,
    .adj_in_range_i, .adj_chan_i, .chan_enabled_i, .host_run_mode_i,
    .bus_error_i, .host_timeout_i, .host_wdt_i, .unit_dup_i,
    .table_mismatch_i, .unit_number_i, .ratio_chan_used_i, .scaling_en_i,
    .scale_upper_i, .scale_lower_i, .ratio_set_i, .hold_sel_i,
    .avg_count_i, .conv_mode_i, .out_set_i, .live_data_i, .status_word_o,
    .conv_data_o, .out_value_o, .base_addr_o, .conv_run_o, .run_led_o,
    .unit_error_led_o, .host_error_led_o, .adjusting_led_o);

  ioas_host_model host (
    .clk_sys_i, .status_word_i(status_word_o), .refresh_o(refresh_i),
    .restart_o(restart_bit_i), .run_mode_o(host_run_mode_i),
    .bus_err_o(bus_error_i), .timeout_o(host_timeout_i),
    .wdt_o(host_wdt_i));

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wait_clk(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask

  // Restart, look inside the restart window, then wait it out
  task automatic restart();
    host.pulse_restart();
    wait_clk(6);
    check("restart data", conv_data_o, 16'h0000);
    check("restart output", out_value_o, 16'h0000);
    wait_clk(16);
  endtask

  // Hang guard, well above the nine hundred or so cycles the run needs
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    wait_clk(2);
    check("reset status", status_word_o, 16'h0000);
    check("reset base", base_addr_o, 16'h07D0);
    @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    wait_clk(20);
    check("base address", base_addr_o, 16'h0848);
    $display("test reset done");
    // Table rows: settings take effect only across a restart
    for (i = 0; i < 13; i++) begin
      @(posedge clk_sys_i);
      ratio_chan_used_i <= rows[i].used;
      scaling_en_i <= rows[i].scl;
      scale_upper_i <= rows[i].up;
      scale_lower_i <= rows[i].lo;
      ratio_set_i <= rows[i].ratio;
      hold_sel_i <= rows[i].hold;
      avg_count_i <= rows[i].avg;
      conv_mode_i <= rows[i].mode;
      restart();
      host.read_status(st);
      check("status", st, rows[i].st);
      check("unit error led", unit_error_led_o, rows[i].st != 0);
      check("run led", run_led_o, rows[i].st == 0);
      check("conv run", conv_run_o, rows[i].st == 0);
      check("data", conv_data_o, rows[i].st != 0 ? 16'h0000 : live_data_i);
      $display("test row %0d done", i);
    end
    // Flags stay until restart even after the cause is gone
    @(posedge clk_sys_i);
    hold_sel_i <= 16'h0002;
    avg_count_i <= 16'h0000;
    wait_clk(6);
    host.read_status(st);
    check("held flags", st, 16'h0C00);
    restart();
    host.read_status(st);
    check("cleared flags", st, 16'h0000);
    check("output", out_value_o, 16'h0555);
    $display("test flag hold done");
    // Host faults with full-scale output hold selected
    host.set_faults(1'b0, 1'b1, 1'b0, 1'b0);
    wait_clk(5);
    check("bus err led", host_error_led_o, 1'b1);
    check("bus err data", conv_data_o, 16'h0000);
    check("bus err out", out_value_o, 16'hFFFF);
    host.set_faults(1'b0, 1'b0, 1'b0, 1'b0);
    wait_clk(5);
    host.set_faults(1'b0, 1'b0, 1'b1, 1'b0);
    wait_clk(5);
    live_data_i <= 16'h4321;
    out_set_i <= 16'h0666;
    wait_clk(5);
    check("silent data", conv_data_o, 16'h1234);
    check("silent out", out_value_o, 16'h0555);
    host.set_faults(1'b0, 1'b0, 1'b0, 1'b1);
    wait_clk(5);
    check("watchdog out", out_value_o, 16'hFFFF);
    host.set_faults(1'b0, 1'b0, 1'b0, 1'b0);
    $display("test host faults done");
    // Bad unit number, duplicate number, table mismatch
    for (i = 0; i < 3; i++) begin
      @(posedge clk_sys_i);
      unit_number_i <= (i == 0) ? 8'h60 : 8'h0C;
      unit_dup_i <= (i == 1);
      table_mismatch_i <= (i == 2);
      restart();
      check("unit led", host_error_led_o, 1'b1);
      check("unit run", conv_run_o, 1'b0);
      check("unit data", conv_data_o, 16'h0000);
      check("unit out", out_value_o, 16'h0000);
    end
    $display("test unit faults done");
    // Adjustment mode: channel and range cases
    for (i = 0; i < 5; i++) begin
      @(posedge clk_sys_i);
      unit_number_i <= 8'h0C;
      table_mismatch_i <= 1'b0;
      adjust_mode_i <= 1'b1;
      adj_chan_i <= achan[i];
      chan_enabled_i <= aen[i];
      adj_in_range_i <= arng[i];
      restart();
      host.read_status(st);
      check("adjust status", st, ast[i]);
      if (i == 2) begin
        check("adjust live", conv_data_o, live_data_i);
      end
    end
    n = 0;
    prev = adjusting_led_o;
    repeat (20) begin
      wait_clk(1);
      if (adjusting_led_o !== prev) n++;
      prev = adjusting_led_o;
    end
    check("blink", n >= 3, 1'b1);
    // Host in run mode while adjusting: freeze and bit 15 only
    host.set_faults(1'b1, 1'b0, 1'b0, 1'b0);
    wait_clk(5);
    live_data_i <= 16'h2468;
    wait_clk(5);
    check("halt data", conv_data_o, 16'h4321);
    host.read_status(st);
    check("halt status", st, 16'h8000);
    // Recovery: leave adjust mode, then restart
    @(posedge clk_sys_i);
    adjust_mode_i <= 1'b0;
    host.set_faults(1'b0, 1'b0, 1'b0, 1'b0);
    restart();
    host.read_status(st);
    check("recovered", st, 16'h0000);
    check("recovered run", run_led_o, 1'b1);
    $display("test adjust done");
    end_sim();
  end
endmodule
